/* File: src/rdc_pkg.sv */
// constants shared by the resolver position output port
package rdc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int FREEZE_MAX_NS = 490;
  localparam int ENABLE_MAX_NS = 110;
  localparam int BYTE_SEL_MAX_NS = 140;
  localparam int BUSY_MIN_NS = 150;
  // a least time rounds up to whole cycles
  localparam int BUSY_CYCLES = (BUSY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest times round down
  localparam int FREEZE_MAX_CYCLES = FREEZE_MAX_NS / CLK_PERIOD_NS;
  localparam int ENABLE_MAX_CYCLES = ENABLE_MAX_NS / CLK_PERIOD_NS;
  localparam int BYTE_SEL_MAX_CYCLES = BYTE_SEL_MAX_NS / CLK_PERIOD_NS;

  // ****************************************
  // position word
  // ****************************************
  localparam int POS_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [POS_W-1:0] POS_RESET = 16'h0000;
  localparam int BUSY_CNT_W = 6;
  localparam logic [BUSY_CNT_W-1:0] BUSY_LOAD = BUSY_CNT_W'(BUSY_CYCLES);

  // ****************************************
  // resolution select codes {hi, lo}
  // ****************************************
  typedef enum logic [1:0] {
    RES_10 = 2'h0,
    RES_12 = 2'h1,
    RES_14 = 2'h2,
    RES_16 = 2'h3
  } res_e;
  localparam res_e RES_RESET = RES_16;

  // one lsb of each resolution, word is left-justified
  localparam logic [POS_W-1:0] STEP_10 = 16'h0040;
  localparam logic [POS_W-1:0] STEP_12 = 16'h0010;
  localparam logic [POS_W-1:0] STEP_14 = 16'h0004;
  localparam logic [POS_W-1:0] STEP_16 = 16'h0001;
  localparam logic [POS_W-1:0] MASK_10 = 16'hffc0;
  localparam logic [POS_W-1:0] MASK_12 = 16'hfff0;
  localparam logic [POS_W-1:0] MASK_14 = 16'hfffc;
  localparam logic [POS_W-1:0] MASK_16 = 16'hffff;

endpackage

/* File: src/tracking_counter.sv */
// up/down position counter stepping one lsb of the selected resolution
`timescale 1ns/1ps
`default_nettype none
module tracking_counter
  import rdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic [POS_W-1:0] step_size,
  input wire logic [POS_W-1:0] res_mask,
  input wire logic track_step,
  input wire logic track_up,
  input wire logic load,
  input wire logic [POS_W-1:0] load_value,
  // state
  output logic [POS_W-1:0] count,
  output logic wrapped
);

  logic [POS_W-1:0] count_reg;
  logic [POS_W-1:0] count_next;
  logic wrap_reg;
  logic wrap_next;
  logic [POS_W-1:0] base;

  always_comb begin
    // low bits below the lsb are dropped so a resolution change stays on grid
    base = count_reg & res_mask;
    count_next = base;
    wrap_next = 1'b0;
    if (load) begin
      count_next = load_value & res_mask;
    end else if (track_step) begin
      if (track_up) begin
        count_next = base + step_size;
        wrap_next = (base == res_mask);
      end else begin
        count_next = base - step_size;
        wrap_next = (base == POS_RESET);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_reg <= POS_RESET;
      wrap_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      wrap_reg <= wrap_next;
    end
  end

  assign count = count_reg;
  assign wrapped = wrap_reg;

  // ****************************************
  // checks
  // ****************************************
  step_up_one_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    track_step && track_up && !load |=> count == (($past(count) & $past(res_mask))
      + $past(step_size)))
    else $error("counter did not step up by one lsb");
  monotonic_up_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    track_step && track_up && !load && $stable(res_mask) && (count & res_mask) != res_mask
      |=> count > $past(count))
    else $error("position not monotonic while rising");

endmodule
`default_nettype wire

/* File: src/resolver_position_output_port.sv */
// digital position output port of a tracking resolver-to-digital converter
// Function
// - two select pins choose 10/12/14/16 bit resolution
// - unconnected select pins default to 16 bits
// - position is unsigned binary fraction of turn
// - position word updates continuously, no conversion request
// - three-state pins, one word or two bytes
// - freeze low holds the output latch steady
// - output enable low drives data pins, except while load is low
// - output enable high releases all data pins
// - byte select picks msb or lsb on low pins
// - keep tracking up to the maximum rotation rate
// - monotonic steps, at most four missing codes
// - ripple output marks whole-turn wrap for counters
// - busy high while the position word changes
// - direction high counting up, low counting down
// - load low loads counter from the data pins
`timescale 1ns/1ps
`default_nettype none
module resolver_position_output_port
  import rdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // resolution select, each with a driven flag standing in for the pull-up
  input wire logic resolution_select_hi,
  input wire logic resolution_select_hi_driven,
  input wire logic resolution_select_lo,
  input wire logic resolution_select_lo_driven,
  // tracking loop steps
  input wire logic track_step,
  input wire logic track_up,
  // host controls
  input wire logic freeze_n,
  input wire logic enable_n,
  input wire logic byte_sel,
  input wire logic data_load_n,
  input wire logic data_load_n_driven,
  // position data pins, [15:8] are the eight lowest-numbered pins
  input wire logic [POS_W-1:0] position_data_pins_in,
  output logic [POS_W-1:0] position_data_pins_out,
  output logic position_data_pins_oe,
  // counting outputs
  output logic busy,
  output logic direction,
  output logic ripple
);

  // ****************************************
  // resolution
  // ****************************************
  res_e res_reg;
  res_e res_next;
  logic [POS_W-1:0] step_size;
  logic [POS_W-1:0] res_mask;
  logic sel_hi;
  logic sel_lo;
  logic load;

  always_comb begin
    sel_hi = resolution_select_hi | ~resolution_select_hi_driven;
    sel_lo = resolution_select_lo | ~resolution_select_lo_driven;
    res_next = res_e'({sel_hi, sel_lo});
  end

  always_comb begin
    unique case (res_reg)
      RES_10: begin
        step_size = STEP_10;
        res_mask = MASK_10;
      end
      RES_12: begin
        step_size = STEP_12;
        res_mask = MASK_12;
      end
      RES_14: begin
        step_size = STEP_14;
        res_mask = MASK_14;
      end
      RES_16: begin
        step_size = STEP_16;
        res_mask = MASK_16;
      end
    endcase
  end

  // an undriven load pin reads high, like its pull-up
  assign load = data_load_n_driven & ~data_load_n;

  // ****************************************
  // counter
  // ****************************************
  logic [POS_W-1:0] count;
  logic wrapped;

  // one step per cycle at most; the top rate of every resolution is far below it
  tracking_counter u_counter (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .step_size(step_size),
    .res_mask(res_mask),
    .track_step(track_step),
    .track_up(track_up),
    .load(load),
    .load_value(position_data_pins_in),
    .count(count),
    .wrapped(wrapped)
  );

  // ****************************************
  // output latch and pins
  // ****************************************
  logic [POS_W-1:0] latch_reg;
  logic [POS_W-1:0] latch_next;
  logic [POS_W-1:0] pins_reg;
  logic [POS_W-1:0] pins_next;
  logic oe_reg;
  logic oe_next;

  always_comb begin
    latch_next = latch_reg;
    if (freeze_n) begin
      latch_next = count & res_mask;
    end
    pins_next[BYTE_W-1:0] = latch_reg[BYTE_W-1:0];
    if (byte_sel) begin
      pins_next[POS_W-1:BYTE_W] = latch_reg[POS_W-1:BYTE_W];
    end else begin
      pins_next[POS_W-1:BYTE_W] = latch_reg[BYTE_W-1:0];
    end
    // pins turn round to inputs while the counter is loaded from them
    oe_next = ~enable_n & ~load;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      res_reg <= RES_RESET;
      latch_reg <= POS_RESET;
      pins_reg <= POS_RESET;
      oe_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      latch_reg <= latch_next;
      pins_reg <= pins_next;
      oe_reg <= oe_next;
    end
  end

  // ****************************************
  // busy, direction, ripple
  // ****************************************
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_next;
  logic busy_reg;
  logic busy_next;
  logic dir_reg;
  logic dir_next;
  logic ripple_reg;
  logic ripple_next;

  always_comb begin
    busy_cnt_next = busy_cnt_reg;
    dir_next = dir_reg;
    ripple_next = ripple_reg;
    if (track_step || load) begin
      // a new change restarts the pulse so it covers the latest update
      busy_cnt_next = BUSY_LOAD;
    end else if (busy_cnt_reg != '0) begin
      busy_cnt_next = busy_cnt_reg - 1'b1;
    end
    busy_next = (busy_cnt_next != '0);
    if (track_step) begin
      dir_next = track_up;
      ripple_next = 1'b0;
    end
    if (wrapped) begin
      ripple_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_cnt_reg <= '0;
      busy_reg <= 1'b0;
      dir_reg <= 1'b1;
      ripple_reg <= 1'b0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
      busy_reg <= busy_next;
      dir_reg <= dir_next;
      ripple_reg <= ripple_next;
    end
  end

  assign position_data_pins_out = pins_reg;
  assign position_data_pins_oe = oe_reg;
  assign busy = busy_reg;
  assign direction = dir_reg;
  assign ripple = ripple_reg;

  // ****************************************
  // checks
  // ****************************************
  res_select_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    resolution_select_hi_driven && resolution_select_lo_driven
      |=> res_reg == res_e'($past({resolution_select_hi, resolution_select_lo})))
    else $error("resolution does not follow the select pins");
  res_default_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !resolution_select_hi_driven && !resolution_select_lo_driven |=> res_reg == RES_16)
    else $error("floating selects did not give 16 bits");
  latch_track_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    freeze_n |=> latch_reg == ($past(count) & $past(res_mask)))
    else $error("latch not following the counter");
  freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !freeze_n && !$past(freeze_n) && $stable(byte_sel) |=> $stable(position_data_pins_out))
    else $error("frozen word changed on the pins");
  enable_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !enable_n && !load |=> position_data_pins_oe)
    else $error("pins not driven after enable");
  disable_float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    enable_n |=> !position_data_pins_oe)
    else $error("pins still driven while disabled");
  byte_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    byte_sel |=> position_data_pins_out[15:8] == $past(latch_reg[15:8]))
    else $error("msb not on the low pins");
  busy_width_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    track_step |=> busy[*8])
    else $error("busy pulse too short");
  dir_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    track_step |=> direction == $past(track_up))
    else $error("direction does not match counting sense");
  ripple_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrapped |=> ripple)
    else $error("ripple missed a wrap");
  load_turn_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    load |=> !position_data_pins_oe && count == ($past(position_data_pins_in)
      & $past(res_mask)))
    else $error("load did not take the pin value");

  cov_freeze_read_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    !freeze_n ##1 !freeze_n && !enable_n ##1 position_data_pins_oe);
  cov_byte_swap_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    byte_sel ##1 !byte_sel && !enable_n);
  cov_wrap_c: cover property (@(posedge clk_sys) disable iff (!nrst) ripple);
  cov_load_c: cover property (@(posedge clk_sys) disable iff (!nrst) load ##1 !load);

endmodule
`default_nettype wire

/* File: dv/host_reader.sv */
// host processor model reading the position port as one word or two bytes
`timescale 1ns/1ps
`default_nettype none
module host_reader
  import rdc_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // command from the bench
  input wire logic rd_req,
  input wire logic rd_bytes,
  // bus side
  input wire logic [15:0] bus,
  output logic freeze_n,
  output logic enable_n,
  output logic byte_sel,
  // result
  output logic rd_done,
  output logic [15:0] rd_data
);
  // ****************************************
  // read cycle
  // ****************************************
  initial begin
    freeze_n = 1'b1;
    enable_n = 1'b1;
    byte_sel = 1'b0;
    rd_done = 1'b0;
    rd_data = 16'h0000;
    forever begin
      @(posedge clk_sys);
      if (rd_req) begin
        freeze_n <= 1'b0;
        // frozen data is only promised after the longest settling time
        repeat (FREEZE_MAX_CYCLES) @(posedge clk_sys);
        enable_n <= 1'b0;
        byte_sel <= 1'b1;
        // byte select is the slower of the two, so its wait covers enable too
        repeat (BYTE_SEL_MAX_CYCLES) @(posedge clk_sys);
        if (rd_bytes) begin
          rd_data[15:8] <= bus[15:8];
          byte_sel <= 1'b0;
          repeat (BYTE_SEL_MAX_CYCLES) @(posedge clk_sys);
          rd_data[7:0] <= bus[15:8];
        end else begin
          rd_data <= bus;
        end
        rd_done <= 1'b1;
        enable_n <= 1'b1;
        freeze_n <= 1'b1;
        @(posedge clk_sys);
        rd_done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the resolver position output port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  // undriven selects idle low so only the pull-up can give 16 bits
  logic sel_hi = 1'b0, sel_lo = 1'b0, sel_drv = 1'b0;
  logic track_step = 1'b0, track_up = 1'b1;
  logic data_load_n = 1'b1, ld_drv = 1'b1, rd_req = 1'b0, rd_bytes = 1'b0;
  logic freeze_n, enable_n, byte_sel, rd_done, oe, busy, direction, ripple;
  logic [15:0] load_val = 16'h0000, pins_out, rd_data, mdl, msk, stp;
  logic [31:0] rnd = 32'h0f10fb72;
  logic [15:0] exp_q[$];
  int fails = 0, num_checks = 0, cyc = 0;
  // released pins show the inverse so stale data never looks valid
  wire logic [15:0] bus = oe ? pins_out : (!data_load_n ? load_val : ~pins_out);

  always #2.5 clk_sys = ~clk_sys;

  resolver_position_output_port i_resolver_position_output_port (
    .clk_sys(clk_sys), .nrst(nrst),
    .resolution_select_hi(sel_hi), .resolution_select_hi_driven(sel_drv),
    .resolution_select_lo(sel_lo), .resolution_select_lo_driven(sel_drv),
    .track_step(track_step), .track_up(track_up),
    .freeze_n(freeze_n), .enable_n(enable_n), .byte_sel(byte_sel),
    .data_load_n(data_load_n), .data_load_n_driven(ld_drv),
    .position_data_pins_in(bus), .position_data_pins_out(pins_out),
    .position_data_pins_oe(oe), .busy(busy), .direction(direction), .ripple(ripple));

  host_reader i_host_reader (
    .clk_sys(clk_sys), .rd_req(rd_req), .rd_bytes(rd_bytes), .bus(bus),
    .freeze_n(freeze_n), .enable_n(enable_n), .byte_sel(byte_sel),
    .rd_done(rd_done), .rd_data(rd_data));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic set_res(input logic [1:0] code);
    @(posedge clk_sys);
    sel_drv <= 1'b1;
    {sel_hi, sel_lo} <= code;
    stp = 16'h0001 << (6 - 2 * code);
    msk = 16'hffff << (6 - 2 * code);
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic step(input logic up, input logic wrap);
    logic w;
    @(posedge clk_sys);
    track_step <= 1'b1;
    track_up <= up;
    @(posedge clk_sys);
    track_step <= 1'b0;
    // random steps may hit an end of the range too
    w = up ? (mdl == msk) : (mdl == 16'h0000);
    mdl = up ? mdl + stp : mdl - stp;
    #1;
    check("direction", direction, up);
    check("busy", busy, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    check("ripple", ripple, wrap | w);
  endtask

  task automatic load(input logic [15:0] v);
    @(posedge clk_sys);
    data_load_n <= 1'b0;
    load_val <= v;
    @(posedge clk_sys);
    data_load_n <= 1'b1;
    mdl = v & msk;
  endtask

  task automatic do_read(input logic bytes, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_bytes <= bytes;
    @(posedge clk_sys);
    rd_req <= 1'b0;
  endtask

  task automatic wait_done;
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    #1;
    check("oe idle", oe, 1'b0);
  endtask

  // ****************************************
  // result watcher and timeout
  // ****************************************
  always @(posedge clk_sys) begin
    cyc++;
    if (rd_done === 1'b1 && exp_q.size() != 0) begin
      check("read word", rd_data, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    mdl = 16'h0000;
    stp = 16'h0001;
    msk = 16'hffff;
    @(posedge clk_sys);
    #1;
    check("direction reset", direction, 1'b1);
    check("oe reset", oe, 1'b0);
    // floating selects must give 16-bit steps
    step(1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    do_read(1'b0, mdl);
    wait_done();
    for (int c = 0; c < 4; c++) begin
      set_res(c[1:0]);
      rnd = xs(rnd);
      load(rnd[15:0]);
      repeat (6) begin
        rnd = xs(rnd);
        step(rnd[0], 1'b0);
      end
      repeat (4) @(posedge clk_sys);
      do_read(1'b0, mdl);
      wait_done();
      do_read(1'b1, mdl);
      wait_done();
    end
    // wrap both ways at 10 bits
    set_res(2'h0);
    load(16'hffff);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    repeat (32) @(posedge clk_sys);
    #1;
    check("busy idle", busy, 1'b0);
    // a step while frozen must not reach the pins
    do_read(1'b0, mdl);
    repeat (2) @(posedge clk_sys);
    step(1'b1, 1'b0);
    wait_done();
    repeat (4) @(posedge clk_sys);
    do_read(1'b0, mdl);
    wait_done();
    // a floating load pin reads high, so a low level there must not load
    @(posedge clk_sys);
    ld_drv <= 1'b0;
    data_load_n <= 1'b0;
    load_val <= 16'h1234;
    @(posedge clk_sys);
    data_load_n <= 1'b1;
    ld_drv <= 1'b1;
    repeat (4) @(posedge clk_sys);
    do_read(1'b0, mdl);
    wait_done();
    summarize();
  end
endmodule
`default_nettype wire
